// ### src/cdo_ctrl.sv
// Clock divider with per-pair output enables set over a serial slave port
//
// Functional notes
// - Select code 00 or open pins passes the reference clock undivided; default.
// - Select codes 01, 10, 11 divide all outputs by two, four, eight.
// - Select pins are asynchronous and are synchronised before use.
// - Enable bit zero drives the pair; one puts it in high impedance.
// - The enable bits live in serial register zero.
// - Reset clears all eight enable bits so every pair is enabled.
// - After a completed write the stored mask alone sets the enables.
// - Enable changes arrive with no timing relation to the reference clock; the code applies them only while the divided clock is low.
// - Mask bit seven maps to pair seven, bit zero to pair zero.
// - Slave answers only address 11010 followed by the two address pins.
// - Address byte bit zero selects read or write.
// - Write transactions follow start, address, register index, data, acknowledge, stop; reads skip the register index.
// - Acknowledge holds SDA low from before SCL rise until SCL fall.
// - Enable change takes effect within one microsecond of the stop at divide by one, two or four only.
`timescale 1ns/100ps
`default_nettype none
`include "cdo_map.svh"
module cdo_ctrl #(
    parameter int NUM_PAIRS = 8
) (
    // Clock, reset and enable
    input  wire logic                 clk,
    input  wire logic                 rst,
    input  wire logic                 ce,
    // Reference clock pins
    input  wire logic                 ref_clock_pos,
    input  wire logic                 ref_clock_neg,
    // Divide select and address straps
    input  wire logic                 div_select_hi,
    input  wire logic                 div_select_lo,
    input  wire logic                 addr_pin_hi,
    input  wire logic                 addr_pin_lo,
    // Serial port
    input  wire logic                 scl_in,
    input  wire logic                 sda_in,
    output logic                      sda_out,
    output logic                      sda_oe_n,
    // Clock outputs
    output logic [NUM_PAIRS-1:0]      clock_out_pair,
    output logic [NUM_PAIRS-1:0]      clock_out_pair_inv,
    output logic [NUM_PAIRS-1:0]      clock_out_oe_n
);
    localparam int EN_LIMIT = `CDO_EN_LIMIT_CYC;

    // Refuse a width the mask register cannot serve
    if (NUM_PAIRS != 8) begin : g_bad_pairs
        $error("NUM_PAIRS must equal the 8-bit mask width");
    end

    // ************************************************
    // Pin synchronisers
    // ************************************************
    logic [5:0] pin_s1_q, pin_s2_q;
    logic       ref_lvl;
    cdo_pkg::cdo_div_code_t div_select_code;
    logic [1:0] addr_pins;

    // Two stages for every asynchronous pin
    always_ff @(posedge clk) begin
        if (rst) begin
            pin_s1_q <= 6'h00;
            pin_s2_q <= 6'h00;
        end else if (ce) begin
            pin_s1_q <= {ref_clock_pos, ref_clock_neg, div_select_hi, div_select_lo,
                         addr_pin_hi, addr_pin_lo};
            pin_s2_q <= pin_s1_q;
        end
    end

    // Decoded synchronised pins
    assign ref_lvl         = pin_s2_q[5] & ~pin_s2_q[4];
    assign div_select_code = pin_s2_q[3:2];
    assign addr_pins       = pin_s2_q[1:0];

    // ************************************************
    // Divider
    // ************************************************
    logic                   ref_p_q, ref_rise;
    logic [2:0]             div_cnt_q;
    cdo_pkg::cdo_div_code_t code_q;
    logic                   div_q, div_d;

    assign ref_rise = ref_lvl & ~ref_p_q;

    // Count reference rises; new code taken only at wrap so no runt cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            ref_p_q   <= 1'b0;
            div_cnt_q <= 3'h0;
            code_q    <= `CDO_DIV1;
        end else if (ce) begin
            ref_p_q <= ref_lvl;
            if (ref_rise) begin
                div_cnt_q <= div_cnt_q + 3'h1;
                if (div_cnt_q == 3'h7) begin
                    code_q <= div_select_code;
                end
            end
        end
    end

    // Level of the common divided clock
    always_comb begin
        case (code_q)
            `CDO_DIV1: div_d = ref_lvl;
            `CDO_DIV2: div_d = div_cnt_q[0];
            `CDO_DIV4: div_d = div_cnt_q[1];
            `CDO_DIV8: div_d = div_cnt_q[2];
            default:   div_d = ref_lvl;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            div_q <= 1'b0;
        end else if (ce) begin
            div_q <= div_d;
        end
    end

    // ************************************************
    // Serial slave and enable application
    // ************************************************
    logic [7:0] mask_q;
    logic       commit_stb;
    logic [7:0] active_q;
    logic       apply_pend_q;

    cdo_i2c_slave u_slave (
        .clk        (clk),
        .rst        (rst),
        .ce         (ce),
        .scl_in     (scl_in),
        .sda_in     (sda_in),
        .sda_oe_n   (sda_oe_n),
        .addr_pins  (addr_pins),
        .mask_rd    (mask_q),
        .mask_q     (mask_q),
        .commit_stb (commit_stb)
    );

    // Open drain: the data level is always low, only the enable moves
    assign sda_out = 1'b0;

    // Move the mask to the outputs only while the clock is low
    always_ff @(posedge clk) begin
        if (rst) begin
            active_q     <= `CDO_OUT_EN_MASK_RST;
            apply_pend_q <= 1'b0;
        end else if (ce) begin
            if (commit_stb | apply_pend_q) begin
                if (~div_d) begin
                    active_q     <= mask_q;
                    apply_pend_q <= 1'b0;
                end else begin
                    apply_pend_q <= 1'b1;
                end
            end
        end
    end

    // Per-pair output flops, bit i drives pair i
    for (genvar i = 0; i < NUM_PAIRS; i++) begin : g_pair
        always_ff @(posedge clk) begin
            if (rst) begin
                clock_out_pair[i]     <= 1'b0;
                clock_out_pair_inv[i] <= 1'b1;
                clock_out_oe_n[i]     <= 1'b0;
            end else if (ce) begin
                clock_out_pair[i]     <= div_d & ~active_q[i];
                clock_out_pair_inv[i] <= ~(div_d & ~active_q[i]);
                clock_out_oe_n[i]     <= active_q[i];
            end
        end
    end

    // ************************************************
    // Checks
    // ************************************************
    logic [7:0] pend_age_q;

    // Age of an unapplied commit
    always_ff @(posedge clk) begin
        if (rst | ~apply_pend_q) begin
            pend_age_q <= 8'h00;
        end else if (ce && pend_age_q != 8'hff) begin
            pend_age_q <= pend_age_q + 8'h01;
        end
    end

    AST_DIV1_PASS: assert property (@(posedge clk) disable iff (rst)
        ce && $past(ce) && code_q == `CDO_DIV1 && active_q[0] == 1'b0
        |=> clock_out_pair[0] == $past(ref_lvl))
        else $error("divide by one does not pass reference");
    AST_DIV2_TOGGLE: assert property (@(posedge clk) disable iff (rst)
        ce && code_q == `CDO_DIV2 && ref_rise && div_cnt_q != 3'h7 ##1 ce
        |=> div_q != $past(div_q))
        else $error("divide by two does not toggle");
    AST_OE_FOLLOWS: assert property (@(posedge clk) disable iff (rst)
        ce |=> clock_out_oe_n == $past(active_q))
        else $error("output enable not following mask");
    AST_RESET_EN: assert property (@(posedge clk)
        rst |=> active_q == 8'h00 && mask_q == 8'h00 && clock_out_oe_n == 8'h00)
        else $error("reset did not enable all pairs");
    AST_COMMIT_APPLY: assert property (@(posedge clk) disable iff (rst)
        ce && commit_stb && !div_d |=> active_q == $past(mask_q))
        else $error("committed mask not applied");
    AST_DIS_LOW: assert property (@(posedge clk) disable iff (rst)
        ce && active_q[7] |=> clock_out_pair[7] == 1'b0)
        else $error("disabled pair seven still toggles");
    AST_NO_RUNT: assert property (@(posedge clk) disable iff (rst)
        ce && div_d |=> $stable(active_q))
        else $error("enable changed while clock high");
    AST_EN_LIMIT: assert property (@(posedge clk) disable iff (rst)
        code_q != `CDO_DIV8 |-> pend_age_q < 8'(EN_LIMIT))
        else $error("enable change later than limit");
    AST_EN_ONLY_COMMIT: assert property (@(posedge clk) disable iff (rst)
        ce && !commit_stb && !apply_pend_q |=> $stable(active_q))
        else $error("enables changed without a committed write");
endmodule
`default_nettype wire

// ### src/cdo_map.svh
// Register map, address fields and timing constants of the clock divider control
`ifndef CDO_MAP_SVH
`define CDO_MAP_SVH
// Register index of the output enable mask
`define CDO_REG_OUT_EN_MASK 8'h00
`define CDO_OUT_EN_MASK_RST 8'h00
// Unused: reads always return the enable mask, whatever register index was written
`define CDO_RD_UNMAPPED     8'h00
// Fixed upper five bits of the slave address
`define CDO_ADDR_PREFIX     5'h1a
// Read/write bit position in the address byte
`define CDO_RW_BIT          0
// Bits per serial byte
`define CDO_BYTE_BITS       4'h8
// Divide-select codes
`define CDO_DIV1            2'h0
`define CDO_DIV2            2'h1
`define CDO_DIV4            2'h2
`define CDO_DIV8            2'h3
// Stop-to-output-enable limit, in ns and at the 100 ns clock
`define CDO_CLK_PERIOD_NS   100
`define CDO_EN_LIMIT_NS     1000
`define CDO_EN_LIMIT_CYC    (`CDO_EN_LIMIT_NS / `CDO_CLK_PERIOD_NS)
`endif

// ### src/cdo_pkg.sv
// Types shared by the clock divider control design
`default_nettype none
package cdo_pkg;
    // Serial slave sequence states
    typedef enum logic [3:0] {
        SLV_IDLE, SLV_ADDR, SLV_ADDR_ACK, SLV_REG, SLV_REG_ACK,
        SLV_WDATA, SLV_WDATA_ACK, SLV_RDATA, SLV_RDATA_ACK
    } cdo_slv_state_t;
    typedef logic [1:0] cdo_div_code_t;
endpackage
`default_nettype wire

// ### src/cdo_i2c_slave.sv
// Serial slave port holding the enable mask
`timescale 1ns/100ps
`default_nettype none
`include "cdo_map.svh"
module cdo_i2c_slave (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       ce,
    // Serial pins
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            sda_oe_n,
    // Address straps, already synchronised
    input  wire logic [1:0] addr_pins,
    // Register side
    input  wire logic [7:0] mask_rd,
    output logic [7:0]      mask_q,
    output logic            commit_stb
);
    // ************************************************
    // Pin synchronisers and bus conditions
    // ************************************************
    logic [1:0] scl_s_q, sda_s_q;
    logic       scl_p_q, sda_p_q;
    logic       scl_rise, scl_fall, start_c, stop_c;

    // Two stages before any logic, then a delay stage for edges
    always_ff @(posedge clk) begin
        if (rst) begin
            scl_s_q <= 2'h3;
            sda_s_q <= 2'h3;
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
        end else if (ce) begin
            scl_s_q <= {scl_s_q[0], scl_in};
            sda_s_q <= {sda_s_q[0], sda_in};
            scl_p_q <= scl_s_q[1];
            sda_p_q <= sda_s_q[1];
        end
    end

    // Edges and start/stop detection
    assign scl_rise = scl_s_q[1] & ~scl_p_q;
    assign scl_fall = ~scl_s_q[1] & scl_p_q;
    assign start_c  = scl_s_q[1] & scl_p_q & sda_p_q & ~sda_s_q[1];
    assign stop_c   = scl_s_q[1] & scl_p_q & ~sda_p_q & sda_s_q[1];

    // ************************************************
    // Byte sequencer
    // ************************************************
    cdo_pkg::cdo_slv_state_t st_q;
    logic [3:0] cnt_q;
    logic [7:0] sh_q, tx_q, idx_q, wbuf_q;
    logic       rw_q, ack_q, drv_q, nack_q, pend_q;

    // Sample on SCL rise, act and drive on SCL fall
    always_ff @(posedge clk) begin
        if (rst) begin
            st_q   <= cdo_pkg::SLV_IDLE;
            cnt_q  <= 4'h0;
            sh_q   <= 8'h00;
            tx_q   <= 8'h00;
            idx_q  <= 8'h00;
            wbuf_q <= 8'h00;
            rw_q   <= 1'b0;
            ack_q  <= 1'b0;
            drv_q  <= 1'b0;
            nack_q <= 1'b0;
            pend_q <= 1'b0;
        end else if (ce) begin
            if (stop_c) begin
                st_q  <= cdo_pkg::SLV_IDLE;
                ack_q <= 1'b0;
                drv_q <= 1'b0;
                pend_q <= 1'b0;
            end else if (start_c) begin
                st_q  <= cdo_pkg::SLV_ADDR;
                cnt_q <= 4'h0;
                ack_q <= 1'b0;
                drv_q <= 1'b0;
            end else if (scl_rise) begin
                sh_q   <= {sh_q[6:0], sda_s_q[1]};
                cnt_q  <= cnt_q + 4'h1;
                nack_q <= sda_s_q[1];
            end else if (scl_fall) begin
                case (st_q)
                    cdo_pkg::SLV_ADDR: begin
                        if (cnt_q == `CDO_BYTE_BITS) begin
                            if (sh_q[7:1] == {`CDO_ADDR_PREFIX, addr_pins}) begin
                                ack_q <= 1'b1;
                                rw_q  <= sh_q[`CDO_RW_BIT];
                                st_q  <= cdo_pkg::SLV_ADDR_ACK;
                            end else begin
                                st_q <= cdo_pkg::SLV_IDLE;
                            end
                        end
                    end
                    cdo_pkg::SLV_ADDR_ACK: begin
                        ack_q <= 1'b0;
                        cnt_q <= 4'h0;
                        if (rw_q) begin
                            st_q  <= cdo_pkg::SLV_RDATA;
                            tx_q  <= mask_rd;
                            drv_q <= ~mask_rd[7];
                        end else begin
                            st_q <= cdo_pkg::SLV_REG;
                        end
                    end
                    cdo_pkg::SLV_REG: begin
                        if (cnt_q == `CDO_BYTE_BITS) begin
                            idx_q <= sh_q;
                            ack_q <= 1'b1;
                            st_q  <= cdo_pkg::SLV_REG_ACK;
                        end
                    end
                    cdo_pkg::SLV_WDATA: begin
                        if (cnt_q == `CDO_BYTE_BITS) begin
                            if (idx_q == `CDO_REG_OUT_EN_MASK) begin
                                wbuf_q <= sh_q;
                                pend_q <= 1'b1;
                            end
                            ack_q <= 1'b1;
                            st_q  <= cdo_pkg::SLV_WDATA_ACK;
                        end
                    end
                    cdo_pkg::SLV_REG_ACK, cdo_pkg::SLV_WDATA_ACK: begin
                        ack_q <= 1'b0;
                        cnt_q <= 4'h0;
                        st_q  <= cdo_pkg::SLV_WDATA;
                    end
                    cdo_pkg::SLV_RDATA: begin
                        if (cnt_q == `CDO_BYTE_BITS) begin
                            drv_q <= 1'b0;
                            st_q  <= cdo_pkg::SLV_RDATA_ACK;
                        end else begin
                            tx_q  <= {tx_q[6:0], 1'b0};
                            drv_q <= ~tx_q[6];
                        end
                    end
                    cdo_pkg::SLV_RDATA_ACK: begin
                        cnt_q <= 4'h0;
                        if (nack_q) begin
                            st_q <= cdo_pkg::SLV_IDLE;
                        end else begin
                            st_q  <= cdo_pkg::SLV_RDATA;
                            tx_q  <= mask_rd;
                            drv_q <= ~mask_rd[7];
                        end
                    end
                    default: st_q <= cdo_pkg::SLV_IDLE;
                endcase
            end
        end
    end

    // Mask takes a written byte only when the write ends with a stop
    always_ff @(posedge clk) begin
        if (rst) begin
            mask_q     <= `CDO_OUT_EN_MASK_RST;
            commit_stb <= 1'b0;
        end else if (ce) begin
            commit_stb <= stop_c & pend_q;
            if (stop_c & pend_q) begin
                mask_q <= wbuf_q;
            end
        end
    end

    // Open-drain SDA: pulled low while acking or sending a zero
    assign sda_oe_n = ~(ack_q | drv_q);

    // SDA moves only after a detected SCL fall or a bus condition
    AST_SDA_ON_FALL: assert property (@(posedge clk) disable iff (rst)
        $changed(sda_oe_n) |-> $past(scl_fall | start_c | stop_c))
        else $error("SDA changed while SCL high");
    // Acknowledge stands until the following SCL fall
    AST_ACK_HOLD: assert property (@(posedge clk) disable iff (rst)
        ce && ack_q && !scl_fall && !start_c && !stop_c |=> ack_q)
        else $error("acknowledge released before SCL fall");
endmodule
`default_nettype wire

// ### tb/cdo_i2c_master.sv
// Serial bus master model that drives the slave port of the divider control
`timescale 1ns/100ps
`default_nettype none
module cdo_i2c_master (
    // Clock
    input  wire logic clk,
    // Serial wires
    input  wire logic sda_wire,
    output logic      scl,
    output logic      sda_hi
);
    // Half period of the serial clock, in system clocks
    localparam int HALF = 15;

    // Bus idles released, pulled up
    initial begin
        scl = 1'b1;
        sda_hi = 1'b1;
    end

    // One bit slot; data set only while clock low, sampled late in high phase
    task automatic bit_slot(input logic v, output logic s);
        sda_hi = v;
        repeat (HALF) @(negedge clk);
        scl = 1'b1;
        repeat (HALF - 2) @(negedge clk);
        s = sda_wire;
        repeat (2) @(negedge clk);
        scl = 1'b0;
        repeat (5) @(negedge clk);
    endtask

    // Start or repeated start: data falls while clock high
    task automatic start_cond();
        sda_hi = 1'b1;
        repeat (HALF) @(negedge clk);
        scl = 1'b1;
        repeat (HALF) @(negedge clk);
        sda_hi = 1'b0;
        repeat (HALF) @(negedge clk);
        scl = 1'b0;
        repeat (5) @(negedge clk);
    endtask

    // Stop: data rises while clock high; returns at the rising data edge
    task automatic stop_cond();
        sda_hi = 1'b0;
        repeat (HALF) @(negedge clk);
        scl = 1'b1;
        repeat (HALF) @(negedge clk);
        sda_hi = 1'b1;
    endtask

    // Byte out, most significant bit first, then release for acknowledge
    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_slot(b[i], s);
        end
        bit_slot(1'b1, s);
        ack = ~s;
    endtask

    // Byte in, then acknowledge or refuse it
    task automatic recv_byte(input logic nack, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_slot(1'b1, b[i]);
        end
        bit_slot(nack, s);
    endtask
endmodule
`default_nettype wire

// ### tb/tb.sv
// Self-checking bench for the clock divider control
`timescale 1ns/100ps
`default_nettype none
`include "cdo_map.svh"
module tb;
    logic       clk, rst, ce, ref_p, ref_n, div_hi, div_lo, a_hi, a_lo;
    logic       scl, sda_hi_m, sda_out, sda_oe_n;
    logic [7:0] pair, pair_inv, oe_n, m, rd, rd0;
    logic [3:0] acks;
    logic [6:0] dev;
    int         num_errors, tests_run, n;
    // Open-drain wire with pull-up
    wire logic  sda_wire = sda_hi_m & sda_oe_n;

    cdo_ctrl #(.NUM_PAIRS(8)) DUT (.clk(clk), .rst(rst), .ce(ce), .ref_clock_pos(ref_p),
        .ref_clock_neg(ref_n), .div_select_hi(div_hi), .div_select_lo(div_lo),
        .addr_pin_hi(a_hi), .addr_pin_lo(a_lo), .scl_in(scl), .sda_in(sda_wire),
        .sda_out(sda_out), .sda_oe_n(sda_oe_n), .clock_out_pair(pair),
        .clock_out_pair_inv(pair_inv), .clock_out_oe_n(oe_n));
    cdo_i2c_master u_master (.clk(clk), .sda_wire(sda_wire), .scl(scl), .sda_hi(sda_hi_m));

    // ****************************************
    // Clock, reference and watchdog
    // ****************************************
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // Reference at four system clocks per period
    initial begin
        ref_p = 1'b0;
        ref_n = 1'b1;
        forever begin
            repeat (2) @(negedge clk);
            ref_p = ~ref_p;
            ref_n = ~ref_n;
        end
    end
    initial begin
        repeat (60000) @(posedge clk);
        num_errors++;
        $display("[FAIL] watchdog expected done seen timeout");
        tally_and_finish();
    end

    // ****************************************
    // Tasks
    // ****************************************
    task automatic tally_and_finish();
        $display("errors %0d checks %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Write one or two bytes, then allow the enable limit to run out
    task automatic reg_write(input logic [6:0] d, input logic [7:0] idx, input logic [7:0] d0,
                             input logic [7:0] d1, input bit two);
        acks = 4'h0;
        u_master.start_cond();
        u_master.send_byte({d, 1'b0}, acks[3]);
        u_master.send_byte(idx, acks[2]);
        u_master.send_byte(d0, acks[1]);
        if (two) begin
            u_master.send_byte(d1, acks[0]);
        end
        u_master.stop_cond();
        repeat (10) @(negedge clk);
    endtask
    task automatic reg_read(input logic [6:0] d, input bit two);
        acks = 4'h0;
        u_master.start_cond();
        u_master.send_byte({d, 1'b1}, acks[3]);
        if (two) begin
            u_master.recv_byte(1'b0, rd0);
        end
        u_master.recv_byte(1'b1, rd);
        u_master.stop_cond();
        repeat (10) @(negedge clk);
    endtask
    // Count rising edges of one pair and flag any cycle without complement
    task automatic count_rises(input int p, input int ncyc);
        logic prev;
        int   bad;
        n = 0;
        bad = 0;
        prev = pair[p];
        repeat (ncyc) begin
            @(negedge clk);
            if (pair[p] === 1'b1 && prev === 1'b0) n++;
            if (pair_inv[p] !== ~pair[p]) bad++;
            prev = pair[p];
        end
        check("complement", 8'h00, bad[7:0]);
    endtask

    // ****************************************
    // Test sequence
    // ****************************************
    initial begin
        rst = 1'b1;
        ce = 1'b1;
        {div_hi, div_lo} = `CDO_DIV1;
        {a_hi, a_lo} = 2'b10;
        repeat (20) @(negedge clk);
        rst = 1'b0;
        repeat (5) @(negedge clk);
        check("reset enables", `CDO_OUT_EN_MASK_RST, oe_n);
        check("sda released", 8'h01, {7'h00, sda_oe_n});
        // Every divide code, 64 reference periods each
        for (int c = 0; c < 4; c++) begin
            {div_hi, div_lo} = c[1:0];
            repeat (80) @(negedge clk);
            count_rises(3, 256);
            if (n >= (64 >> c) - 1 && n <= (64 >> c) + 1) n = 64 >> c;
            check("divided rises", 8'(64 >> c), n[7:0]);
        end
        {div_hi, div_lo} = `CDO_DIV1;
        repeat (80) @(negedge clk);
        dev = {`CDO_ADDR_PREFIX, 2'b10};
        reg_read(dev, 1'b0);
        check("read reset mask", 8'h00, rd);
        reg_write(dev, `CDO_REG_OUT_EN_MASK, 8'ha5, 8'h00, 1'b0);
        check("write acks", 8'h0e, {4'h0, acks});
        check("applied mask", 8'ha5, oe_n);
        count_rises(0, 40);
        check("disabled pair rises", 8'h00, n[7:0]);
        count_rises(1, 40);
        check("enabled pair runs", 8'h01, {7'h00, n > 8});
        reg_read(dev, 1'b0);
        check("read ack", 8'h08, {4'h0, acks});
        check("read mask", 8'ha5, rd);
        // Each strap setting: mismatched address refused, matching one taken
        m = 8'ha5;
        for (int p = 0; p < 4; p++) begin
            {a_hi, a_lo} = p[1:0];
            repeat (5) @(negedge clk);
            reg_write({`CDO_ADDR_PREFIX, ~p[1:0]}, 8'h00, 8'hee, 8'h00, 1'b0);
            check("foreign address", 8'h00, {4'h0, acks});
            check("mask kept", m, oe_n);
            m = 8'h10 | 8'(p);
            reg_write({`CDO_ADDR_PREFIX, p[1:0]}, 8'h00, m, 8'h00, 1'b0);
            check("own address", 8'h0e, {4'h0, acks});
            check("mask taken", m, oe_n);
        end
        {a_hi, a_lo} = 2'b10;
        repeat (5) @(negedge clk);
        reg_write({5'h0a, 2'b10}, 8'h00, 8'hee, 8'h00, 1'b0);
        check("wrong prefix", 8'h00, {4'h0, acks});
        reg_write(dev, 8'h01, 8'hff, 8'h00, 1'b0);
        check("other index acks", 8'h0e, {4'h0, acks});
        check("other index ignored", m, oe_n);
        reg_write(dev, 8'h00, 8'h0f, 8'hf0, 1'b1);
        check("two byte acks", 8'h0f, {4'h0, acks});
        check("last byte wins", 8'hf0, oe_n);
        reg_write(dev, 8'h00, 8'h00, 8'h00, 1'b0);
        check("all enabled", 8'h00, oe_n);
        // Two bytes in one read, both carry the mask
        reg_write(dev, 8'h00, 8'h5a, 8'h00, 1'b0);
        reg_read(dev, 1'b1);
        check("first of two reads", 8'h5a, rd0);
        check("second of two reads", 8'h5a, rd);
        // Clock enable low freezes the outputs
        m = pair;
        ce = 1'b0;
        repeat (20) @(negedge clk);
        check("frozen pairs", m, pair);
        ce = 1'b1;
        // Reset in mid-run enables every pair again
        rst = 1'b1;
        repeat (20) @(negedge clk);
        rst = 1'b0;
        repeat (5) @(negedge clk);
        check("reset enables again", 8'h00, oe_n);
        reg_read(dev, 1'b0);
        check("reset mask read", 8'h00, rd);
        tally_and_finish();
    end
endmodule
`default_nettype wire
